// file: iu_pkg.sv
// Purpose: Shared constants and types of the interrupt unit
// Assumes: 32-bit APB register bus, one system clock
// Notes:   Source numbering is also the fixed polling order
package iu_pkg;

  localparam int NUM_SRC   = 17;
  localparam int NUM_FLAG  = 18;
  localparam int NUM_GRP   = 6;
  localparam int LVL_W     = 2;

  // Register byte offsets
  localparam logic [7:0] OFS_ENABLE   = 8'h00;
  localparam logic [7:0] OFS_PRIORITY = 8'h04;
  localparam logic [7:0] OFS_FLAGS    = 8'h08;
  localparam logic [7:0] OFS_CONTROL  = 8'h0C;
  localparam logic [7:0] OFS_STATUS   = 8'h10;

  // Field positions
  localparam int EN_T2_RELOAD_BIT = 17;
  localparam int EN_GLOBAL_BIT    = 31;
  localparam int CTL_PDOWN_BIT    = 0;
  localparam int CTL_EXT0_EDGE    = 1;
  localparam int CTL_EXT1_EDGE    = 2;

  // Reset values
  localparam logic [31:0] RST_ENABLE   = 32'h0000_0000;
  localparam logic [11:0] RST_PRIORITY = 12'h000;
  localparam logic [2:0]  RST_CONTROL  = 3'h0;

  // Flag bit positions
  localparam int F_EXT0 = 0;
  localparam int F_T0   = 1;
  localparam int F_EXT1 = 2;
  localparam int F_T1   = 3;
  localparam int F_RI   = 4;
  localparam int F_TI   = 5;
  localparam int F_TF2  = 6;
  localparam int F_TIMER2_EXT_RELOAD_FLAG = 7;
  localparam int F_ADC  = 8;
  localparam int F_EXT2 = 9;
  localparam int F_EXT7 = 14;
  localparam int F_EXT8 = 15;
  localparam int F_TC   = 16;
  localparam int F_SYNC_WRITE_COLLISION_FLAG = 17;

  // Source index of the wake-up and CAN requests
  localparam int S_WAKE = 12;
  localparam int S_CAN  = 13;

  typedef logic [15:0] iu_vec_t;

  // Vector address per source, in polling order
  localparam iu_vec_t VECTOR [NUM_SRC] = '{
    16'h0003, 16'h000B, 16'h0013, 16'h001B, 16'h0023, 16'h002B,
    16'h0043, 16'h004B, 16'h0053, 16'h005B, 16'h0063, 16'h006B,
    16'h007B, 16'h008B, 16'h00A3, 16'h00AB, 16'h0093};

  // Priority group per source
  localparam logic [2:0] GROUP [NUM_SRC] = '{
    3'd0, 3'd1, 3'd2, 3'd3, 3'd4, 3'd5,
    3'd0, 3'd1, 3'd2, 3'd3, 3'd4, 3'd5,
    3'd4, 3'd0, 3'd2, 3'd3, 3'd1};

  // Flag cleared by hardware on vectoring, or -1 when software clears
  localparam int HW_CLR_FLAG [NUM_SRC] = '{
    0, 1, 2, 3, -1, -1, -1, 9, 10, 11, 12, 13, -1, -1, 14, 15, -1};

  typedef struct packed {
    logic timer0_overflow;
    logic timer1_overflow;
    logic timer2_overflow;
    logic serial_receive;
    logic serial_transmit;
    logic converter_done;
    logic sync_transfer_complete;
    logic sync_write_collision;
    logic can_request;
  } iu_periph_s;

  typedef struct packed {
    logic          request;
    iu_vec_t       vector;
    logic [LVL_W-1:0] level;
  } iu_cpu_s;

endpackage : iu_pkg

// file: iu_sync.sv
// Purpose: Two-stage synchroniser for pin inputs
// Assumes: Inputs asynchronous to clock
// Notes:   Reset value is all ones, the idle level of the pins
`timescale 1ns/10ps
`default_nettype none
module iu_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input  wire logic             clock,
  input  wire logic             reset_n,
  // Data
  input  wire logic [WIDTH-1:0] async_in,
  output var  logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_q;

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      meta_q   <= '1;
      sync_out <= '1;
    end else begin
      meta_q   <= async_in;
      sync_out <= meta_q;
    end
  end
endmodule : iu_sync
`default_nettype wire

// file: iu_flag.sv
// Purpose: Sticky request flag
// Assumes: Set and clear are same-clock pulses
// Notes:   Set wins over a clear in the same cycle
`timescale 1ns/10ps
`default_nettype none
module iu_flag (
  // Clock and reset
  input  wire logic clock,
  input  wire logic reset_n,
  // Control
  input  wire logic set,
  input  wire logic clear,
  output var  logic flag_q
);
  logic flag_d;

  assign flag_d = set | (flag_q & ~clear);

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      flag_q <= 1'b0;
    end else begin
      flag_q <= flag_d;
    end
  end
endmodule : iu_flag

// file: iu_top.sv
// Purpose: Multi-source interrupt unit with APB register access
// Assumes: Peripheral events are one-cycle pulses on clock
// Notes:   Pins are synchronised before use
//
// Overview of operation
// - Seventeen request sources are arbitrated across four priority levels.
// - Seven sources come from on-chip timers, serial ports, converter and CAN.
// - Ten sources come from pins: timer 2 reload input and external 0 to 8.
// - Sources form six groups of two or three; priority is per group.
// - Each group's level is programmed independently by software.
// - A low pulse on external input 0 ends power-down and vectors wake-up.
// - Fixed vectors for external 0/1, timers 0/1 and the shared serial vector.
// - Timer 2 overflow and external reload share one vector.
// - External 2 to 6 vector eight bytes apart from 004B to 006B.
// - Wake-up vectors to 007B and has no visible request flag; the code shows its request as wake_q, bit 5 of status.
// - Converter, CAN, sync channel, external 7 and 8 vectors; sync has two flags.
// - Timer 2 reload flag sets on a falling reload edge only when enabled.
//
// The implementer's own choices: register access over APB and the register offsets.
`timescale 1ns/10ps
`default_nettype none
module iu_top (
  // Clock and reset
  input  wire logic              clock,
  input  wire logic              reset_n,
  // APB slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [7:0]        paddr,
  input  wire logic [31:0]       pwdata,
  output var  logic [31:0]       prdata,
  output var  logic              pready,
  output var  logic              pslverr,
  // Peripheral events
  input  wire iu_pkg::iu_periph_s periph,
  // Pins
  input  wire logic              ext_irq_input_zero,
  input  wire logic [8:1]        ext_irq_input,
  input  wire logic              timer2_reload_input,
  // CPU core
  output var  iu_pkg::iu_cpu_s   cpu,
  input  wire logic              cpu_ack,
  input  wire logic              cpu_return,
  // Power
  output var  logic              power_down_q
);
  import iu_pkg::*;

  logic [31:0]           enable_q;
  logic [11:0]           priority_q;
  logic [2:0]            control_q;
  logic [3:0]            in_service_q;
  logic [4:0]            index_q;
  logic                  wake_q;
  logic [NUM_FLAG-1:0]   flags;
  logic [NUM_FLAG-1:0]   flag_set;
  logic [NUM_FLAG-1:0]   flag_clr;
  logic [NUM_FLAG-1:0]   hw_clr;
  logic [9:0]            pin_s;
  logic [9:0]            pin_prev_q;
  logic [9:0]            pin_fall;
  logic [NUM_SRC-1:0]    src_req;
  logic [NUM_SRC-1:0]    src_live;

  // Pin synchronisation and falling-edge detection
  iu_sync #(.WIDTH(10)) u_sync (
    .clock    (clock),
    .reset_n  (reset_n),
    .async_in ({timer2_reload_input, ext_irq_input, ext_irq_input_zero}),
    .sync_out (pin_s)
  );

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      pin_prev_q <= '1;
    end else begin
      pin_prev_q <= pin_s;
    end
  end

  assign pin_fall = pin_prev_q & ~pin_s;

  // APB decode
  wire setup_phase  = psel & ~penable;
  wire access_phase = psel & penable;
  wire wr_access    = access_phase & pwrite & pready;
  wire sel_enable   = paddr == OFS_ENABLE;
  wire sel_priority = paddr == OFS_PRIORITY;
  wire sel_flags    = paddr == OFS_FLAGS;
  wire sel_control  = paddr == OFS_CONTROL;
  wire sel_status   = paddr == OFS_STATUS;
  wire addr_mapped  = sel_enable | sel_priority | sel_flags | sel_control | sel_status;
  wire wr_ok        = wr_access & ~pslverr;

  // Flag sources
  wire ext0_edge_mode = control_q[CTL_EXT0_EDGE];
  wire ext1_edge_mode = control_q[CTL_EXT1_EDGE];
  wire ext0_set = ext0_edge_mode ? pin_fall[0] : ~pin_s[0];
  wire ext1_set = ext1_edge_mode ? pin_fall[1] : ~pin_s[1];
  wire timer2_ext_reload_flag_set = pin_fall[9] & enable_q[EN_T2_RELOAD_BIT];

  assign flag_set = {periph.sync_write_collision,
                     periph.sync_transfer_complete,
                     pin_fall[8], pin_fall[7],
                     pin_fall[6:2],
                     periph.converter_done,
                     timer2_ext_reload_flag_set, periph.timer2_overflow,
                     periph.serial_transmit, periph.serial_receive,
                     periph.timer1_overflow, ext1_set,
                     periph.timer0_overflow, ext0_set};

  // Software clears by writing ones; hardware clears on vectoring
  assign flag_clr = (wr_ok & sel_flags ? pwdata[NUM_FLAG-1:0] : '0) | hw_clr;

  for (genvar g = 0; g < NUM_FLAG; g++) begin : g_flag
    iu_flag u_flag (
      .clock   (clock),
      .reset_n (reset_n),
      .set     (flag_set[g]),
      .clear   (flag_clr[g]),
      .flag_q  (flags[g])
    );
  end

  // Requests per source, in polling order
  assign src_req = {flags[F_TC] | flags[F_SYNC_WRITE_COLLISION_FLAG],
                    flags[F_EXT8], flags[F_EXT7],
                    periph.can_request,
                    wake_q,
                    flags[F_EXT2+4:F_EXT2],
                    flags[F_ADC],
                    flags[F_TF2] | flags[F_TIMER2_EXT_RELOAD_FLAG],
                    flags[F_RI] | flags[F_TI],
                    flags[F_T1], flags[F_EXT1],
                    flags[F_T0], flags[F_EXT0]};

  assign src_live = enable_q[EN_GLOBAL_BIT] ? (src_req & enable_q[NUM_SRC-1:0]) : '0;

  // Highest level in service
  logic [LVL_W-1:0] active_lvl;
  logic             any_active;
  assign any_active = |in_service_q;
  always_comb begin
    active_lvl = '0;
    for (int l = 0; l < 4; l++) begin
      if (in_service_q[l]) begin
        active_lvl = LVL_W'(l);
      end
    end
  end

  // Winner: highest group level, then lowest source index
  logic             win_found;
  logic [4:0]       win_idx;
  logic [LVL_W-1:0] win_lvl;
  logic [LVL_W-1:0] src_lvl;
  always_comb begin
    win_found = 1'b0;
    win_idx   = '0;
    win_lvl   = '0;
    src_lvl   = '0;
    for (int i = 0; i < NUM_SRC; i++) begin
      src_lvl = priority_q[2*GROUP[i] +: LVL_W];
      if (src_live[i] && (!win_found || src_lvl > win_lvl)) begin
        win_found = 1'b1;
        win_idx   = 5'(i);
        win_lvl   = src_lvl;
      end
    end
  end

  wire win_ok = win_found & (!any_active | (win_lvl > active_lvl));
  wire taken  = cpu_ack & cpu.request;

  // Hardware clear of the vectored source's flag
  always_comb begin
    hw_clr = '0;
    for (int i = 0; i < NUM_SRC; i++) begin
      if (taken && index_q == 5'(i) && HW_CLR_FLAG[i] >= 0) begin
        hw_clr[HW_CLR_FLAG[i]] = 1'b1;
      end
    end
    if (!ext0_edge_mode) begin
      hw_clr[F_EXT0] = 1'b0;
    end
    if (!ext1_edge_mode) begin
      hw_clr[F_EXT1] = 1'b0;
    end
  end

  // Request to the CPU; dropped for one cycle after an acknowledge
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      cpu     <= '0;
      index_q <= '0;
    end else begin
      cpu.request <= win_ok & ~taken;
      cpu.vector  <= VECTOR[win_idx];
      cpu.level   <= win_lvl;
      index_q     <= win_idx;
    end
  end

  // In-service levels: ack marks, return releases the highest
  logic [3:0] in_service_d;
  always_comb begin
    in_service_d = in_service_q;
    if (cpu_return && any_active) begin
      in_service_d[active_lvl] = 1'b0;
    end
    if (taken) begin
      in_service_d[cpu.level] = 1'b1;
    end
  end

  // Power-down and wake-up
  wire pdown_wr = wr_ok & sel_control & pwdata[CTL_PDOWN_BIT];
  wire wake_hit = power_down_q & ~pin_s[0];
  wire wake_clr = taken & (index_q == 5'(S_WAKE));

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      in_service_q <= '0;
      power_down_q <= 1'b0;
      wake_q       <= 1'b0;
    end else begin
      in_service_q <= in_service_d;
      power_down_q <= (power_down_q | pdown_wr) & ~wake_hit;
      wake_q       <= wake_hit | (wake_q & ~wake_clr);
    end
  end

  // Configuration registers
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      enable_q   <= RST_ENABLE;
      priority_q <= RST_PRIORITY;
      control_q  <= RST_CONTROL;
    end else begin
      if (wr_ok && sel_enable) begin
        enable_q <= pwdata & 32'h8003_FFFF;
      end
      if (wr_ok && sel_priority) begin
        priority_q <= pwdata[11:0];
      end
      if (wr_ok && sel_control) begin
        control_q <= {pwdata[CTL_EXT1_EDGE], pwdata[CTL_EXT0_EDGE], 1'b0};
      end
    end
  end

  // Read mux
  logic [31:0] rd_data;
  always_comb begin
    rd_data = '0;
    unique case (1'b1)
      sel_enable:   rd_data = enable_q;
      sel_priority: rd_data = {20'h0_0000, priority_q};
      sel_flags:    rd_data = {14'h0000, flags};
      sel_control:  rd_data = {29'h0000_0000, control_q[2:1], power_down_q};
      sel_status:   rd_data = {20'h0_0000, cpu.request, index_q, wake_q, 1'b0,
                               in_service_q};
      default:      rd_data = '0;
    endcase
  end

  // APB answer: zero wait, data captured in setup
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      prdata  <= '0;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= setup_phase;
      pslverr <= setup_phase & ~addr_mapped;
      if (setup_phase && !pwrite) begin
        prdata <= rd_data;
      end
    end
  end

endmodule : iu_top
`default_nettype wire

// file: iu_monitor.sv
// Purpose: Port-level checks of the interrupt unit
// Assumes: One clock domain
// Notes:   Attached to iu_top by bind
`timescale 1ns/10ps
`default_nettype none
module iu_monitor (
  // Clock and reset
  input wire logic            clock,
  input wire logic            reset_n,
  // APB
  input wire logic            psel,
  input wire logic            penable,
  input wire logic            pwrite,
  input wire logic [7:0]      paddr,
  input wire logic [31:0]     pwdata,
  input wire logic [31:0]     prdata,
  input wire logic            pready,
  input wire logic            pslverr,
  // Pin and core side
  input wire logic            ext_irq_input_zero,
  input wire iu_pkg::iu_cpu_s cpu,
  input wire logic            cpu_ack,
  input wire logic            power_down_q
);
  import iu_pkg::*;
  default clocking @(posedge clock); endclocking
  default disable iff (!reset_n);
  a_setup_gets_ready:
    assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  a_ready_one_cycle:
    assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  a_idle_no_ready:
    assert property (!psel |=> !pready)
    else $error("ready without select");
  a_err_reads_zero:
    assert property (pready && pslverr && !pwrite |-> prdata == 32'h0000_0000)
    else $error("refused read returned data");
  a_ack_drops_req:
    assert property (cpu.request && cpu_ack |=> !cpu.request)
    else $error("request held after ack");
  a_vector_legal:
    assert property (cpu.request |-> cpu.vector[2:0] == 3'h3 && cpu.vector <= 16'h00AB)
    else $error("vector outside table");
  a_wake_exits:
    assert property (power_down_q && !ext_irq_input_zero |-> ##[1:6] !power_down_q)
    else $error("low pin did not end power-down");
  a_pdown_entry:
    assert property (psel && penable && pready && pwrite && paddr == OFS_CONTROL
      && pwdata[CTL_PDOWN_BIT] && ext_irq_input_zero && $past(ext_irq_input_zero)
      && $past(ext_irq_input_zero, 2) |=> power_down_q)
    else $error("power-down not entered");
endmodule : iu_monitor
bind iu_top iu_monitor u_monitor (.clock(clock), .reset_n(reset_n), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .ext_irq_input_zero(ext_irq_input_zero),
  .cpu(cpu), .cpu_ack(cpu_ack), .power_down_q(power_down_q));
`default_nettype wire

// file: iu_cpu_model.sv
// Purpose: CPU core that fetches offered vectors
// Assumes: Handler lasts a fixed 21 cycles
// Notes:   Acks at once, or 5 cycles late when slow
`timescale 1ns/10ps
`default_nettype none
module iu_cpu_model (
  // Clock and reset
  input  wire logic            clock,
  input  wire logic            reset_n,
  // Interrupt handshake
  input  wire iu_pkg::iu_cpu_s cpu,
  input  wire logic            slow,
  output var  logic            cpu_ack,
  output var  logic            cpu_return,
  // Observation
  output var  logic [15:0]     taken_vec,
  output var  int              taken_cnt
);
  import iu_pkg::*;
  int   wait_q;
  int   hold_q;
  logic busy_q;
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      cpu_ack    <= 1'b0;
      cpu_return <= 1'b0;
      taken_vec  <= 16'h0000;
      taken_cnt  <= 0;
      wait_q     <= 0;
      hold_q     <= 0;
      busy_q     <= 1'b0;
    end else begin
      cpu_ack    <= 1'b0;
      cpu_return <= 1'b0;
      if (busy_q) begin
        hold_q <= hold_q + 1;
        if (hold_q == 20) begin
          cpu_return <= 1'b1;
          busy_q     <= 1'b0;
        end
      end else if (cpu.request) begin
        wait_q <= wait_q + 1;
        if (wait_q >= (slow ? 5 : 0)) begin
          cpu_ack   <= 1'b1;
          taken_vec <= cpu.vector;
          taken_cnt <= taken_cnt + 1;
          busy_q    <= 1'b1;
          wait_q    <= 0;
          hold_q    <= 0;
        end
      end
    end
  end
endmodule : iu_cpu_model
`default_nettype wire

// file: multi_source_interrupt_unit_tb.sv
// Purpose: Self-checking bench of the interrupt unit
// Assumes: CPU model acks and returns each vector
// Notes:   Expected vectors kept here, apart from the design
`timescale 1ns/10ps
`default_nettype none
module multi_source_interrupt_unit_tb;
  import iu_pkg::*;
  logic        clock, reset_n, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata;
  iu_periph_s  periph;
  logic        ext_irq_input_zero, timer2_reload_input, cpu_ack, cpu_return;
  logic [8:1]  ext_irq_input;
  iu_cpu_s     cpu;
  logic        power_down_q, slow;
  logic [15:0] taken_vec;
  int          taken_cnt;
  int          bad_count = 0, n_compared = 0, cycles = 0, want = 0;
  localparam logic [15:0] VEC [19] = '{16'h0003, 16'h000B, 16'h0013, 16'h001B, 16'h0023,
    16'h0023, 16'h002B, 16'h002B, 16'h0043, 16'h004B, 16'h0053, 16'h005B, 16'h0063,
    16'h006B, 16'h008B, 16'h00A3, 16'h00AB, 16'h0093, 16'h0093};
  localparam logic [8:0] PM [19] = '{9'h0, 9'h100, 9'h0, 9'h080, 9'h020, 9'h010, 9'h040,
    9'h0, 9'h008, 9'h0, 9'h0, 9'h0, 9'h0, 9'h0, 9'h001, 9'h0, 9'h0, 9'h004, 9'h002};
  iu_top DUT (.clock(clock), .reset_n(reset_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .periph(periph), .ext_irq_input_zero(ext_irq_input_zero),
    .ext_irq_input(ext_irq_input), .timer2_reload_input(timer2_reload_input), .cpu(cpu),
    .cpu_ack(cpu_ack), .cpu_return(cpu_return), .power_down_q(power_down_q));
  iu_cpu_model u_cpu (.clock(clock), .reset_n(reset_n), .cpu(cpu), .slow(slow),
    .cpu_ack(cpu_ack), .cpu_return(cpu_return), .taken_vec(taken_vec),
    .taken_cnt(taken_cnt));
  task automatic give_verdict();
    $display("compared %0d mismatched %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : give_verdict
  task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : cmp
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    @(posedge clock);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clock);
    penable <= 1'b1;
    do @(posedge clock); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
  endtask : wr
  task automatic chk(input string what, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] r;
    logic        e;
    apb(1'b0, a, 32'h0000_0000, r, e);
    cmp(what, exp, r);
  endtask : chk
  task automatic fire(input int e);
    @(posedge clock);
    case (e)
      0: ext_irq_input_zero <= 1'b0;
      2: ext_irq_input[1] <= 1'b0;
      7: timer2_reload_input <= 1'b0;
      9, 10, 11, 12, 13: ext_irq_input[e-7] <= 1'b0;
      15, 16: ext_irq_input[e-8] <= 1'b0;
      default: periph <= iu_periph_s'(PM[e]);
    endcase
    @(posedge clock);
    ext_irq_input_zero  <= 1'b1;
    ext_irq_input       <= 8'hFF;
    timer2_reload_input <= 1'b1;
    periph              <= iu_periph_s'(PM[e] & 9'h001);
  endtask : fire
  // Waits for the next vector taken, then clears the given flags
  task automatic serve(input logic [15:0] exp, input logic [31:0] clr);
    want++;
    for (int i = 0; i < 300 && taken_cnt < want; i++) @(posedge clock);
    cmp("taken count", 32'(want), 32'(taken_cnt));
    cmp("vector", 32'(exp), 32'(taken_vec));
    periph <= '0;
    wr(OFS_FLAGS, clr);
  endtask : serve
  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 6000) begin
      bad_count++;
      give_verdict();
    end
  end
  initial begin
    logic [31:0] r;
    logic        e;
    reset_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    periph = '0;
    ext_irq_input_zero = 1'b1;
    ext_irq_input = 8'hFF;
    timer2_reload_input = 1'b1;
    slow = 1'b0;
    repeat (8) @(posedge clock);
    reset_n <= 1'b1;
    chk("enable", OFS_ENABLE, 32'h0000_0000);
    chk("priority", OFS_PRIORITY, 32'h0000_0000);
    apb(1'b0, 8'h14, 32'h0000_0000, r, e);
    cmp("slverr", 32'h0000_0001, 32'(e));
    wr(OFS_PRIORITY, 32'h0000_0FFF);
    chk("priority", OFS_PRIORITY, 32'h0000_0FFF);
    wr(OFS_PRIORITY, 32'h0000_0000);
    wr(OFS_CONTROL, 32'h0000_0006);
    wr(OFS_ENABLE, 32'h8001_EFFF);
    fire(7);
    repeat (30) @(posedge clock);
    chk("flags", OFS_FLAGS, 32'h0000_0000);
    wr(OFS_ENABLE, 32'h8003_EFFF);
    for (int k = 0; k < 19; k++) begin
      slow <= (k > 9);
      fire(k);
      serve(VEC[k], 32'h0003_FFFF);
      repeat (30) @(posedge clock);
    end
    for (int p = 0; p < 2; p++) begin
      wr(OFS_PRIORITY, 32'(3 * p));
      @(posedge clock);
      periph <= iu_periph_s'(9'h108);
      @(posedge clock);
      periph <= '0;
      serve(p ? 16'h0043 : 16'h000B, 32'(p << 8));
      serve(p ? 16'h000B : 16'h0043, 32'((1 - p) << 8));
      repeat (30) @(posedge clock);
    end
    wr(OFS_PRIORITY, 32'h0000_0000);
    wr(OFS_ENABLE, 32'h8000_1000);
    wr(OFS_CONTROL, 32'h0000_0007);
    @(posedge clock);
    cmp("power down", 32'h0000_0001, 32'(power_down_q));
    fire(0);
    serve(16'h007B, 32'h0000_0000);
    cmp("power down", 32'h0000_0000, 32'(power_down_q));
    chk("flags", OFS_FLAGS, 32'h0000_0001);
    // Level mode on ext1: flag follows a low pin, a clear loses to it
    wr(OFS_CONTROL, 32'h0000_0002);
    ext_irq_input[1] <= 1'b0;
    repeat (6) @(posedge clock);
    chk("level flag", OFS_FLAGS, 32'h0000_0005);
    wr(OFS_FLAGS, 32'h0000_0004);
    chk("set wins", OFS_FLAGS, 32'h0000_0005);
    ext_irq_input[1] <= 1'b1;
    repeat (6) @(posedge clock);
    wr(OFS_FLAGS, 32'h0000_0004);
    chk("level cleared", OFS_FLAGS, 32'h0000_0001);
    give_verdict();
  end
endmodule : multi_source_interrupt_unit_tb
`default_nettype wire
